// ### hdl/cb_adc_defines.vh
/*
 Constants for the charge-balance converter count readout.
 Assumes inclusion by bare name from the readout module only.
*/
`ifndef CB_ADC_DEFINES_VH
`define CB_ADC_DEFINES_VH
`define CNT_WIDTH      17
`define ADV_COUNT      5'h11
`define DIV_STAGES     12
`define COUNT_RESET    17'h00000
`define ADV_DIV        4'h4
`endif

// ### hdl/charge_balance_adc_count_readout.v
/*
 Grounded-side control of a charge-balance converter: launch sequencing,
 reversible counter, divider chain, parallel load and serial readout.
 Assumes comparator and launch inputs arrive from outside the clock domain;
 the receiving processor samples data on each advance pulse.
*/
// How it works
// R1: Launch steps progress, measure/zero, override stages
// R2: Comparator output follows count direction
// R3: Twelve-stage divider, each halves previous
// R4: Separate conversion-done and autozero-done pulses
// R5: Up/down pulses step counter during measure
// R6: Counter clear pulse zeroes the counter
// R7: Stop loads count into shift register
// R8: Exactly seventeen advance pulses after stop
// R9: Data shifts out one bit per advance
// R10: Processor samples all seventeen bits first
`timescale 1ns/100ps
`include "cb_adc_defines.vh"
module charge_balance_adc_count_readout #(
	parameter MEASURE_CYCLES = 16'h0400,   // Measure phase length in clocks
	parameter ZERO_CYCLES    = 16'h0400    // Autozero phase length in clocks
) (
	// Clock and reset
	input  wire                   clk_sys,
	input  wire                   sys_rst,
	// Raw pins from the isolated side
	input  wire                   conversion_launch,
	input  wire                   count_dir,
	input  wire                   up_pulse,
	input  wire                   down_pulse,
	input  wire                   counter_clear,
	// Sequencing state
	output reg                    in_progress,
	output reg                    measure_zero,
	output reg                    override,
	output reg                    comparator_out,
	output reg                    conversion_done,
	output reg                    autozero_done,
	// Divider chain
	output reg [`DIV_STAGES-1:0]  div_q,
	// Serial readout
	output reg                    advance,
	output reg                    serial_data,
	output reg [`CNT_WIDTH-1:0]   count_value
);

	// Synchroniser stages for five pins
	reg  [4:0]              s1_r;           // First stage, read only by s2
	reg  [4:0]              s2_r;
	reg  [4:0]              s3_r;
	reg  [4:0]              stable_r;       // Accepted level
	wire [4:0]              raw_pins;
	wire [4:0]              rise;

	assign raw_pins = {counter_clear, down_pulse, up_pulse, count_dir, conversion_launch};

	// Three-stage sync; change counts when stages two and three agree.
	// A pin glitch shorter than one clock never reaches stable_r. The third
	// stage costs one clock of latency but hides a late metastable resolve.
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s1_r     <= 5'h00;
			s2_r     <= 5'h00;
			s3_r     <= 5'h00;
			stable_r <= 5'h00;
		end else begin
			s1_r <= raw_pins;
			s2_r <= s1_r;
			s3_r <= s2_r;
			stable_r <= (s2_r & s3_r) | (~(s2_r ^ s3_r) & s2_r) | ((s2_r ^ s3_r) & stable_r);
		end
	end

	// One-cycle edges of accepted levels
	assign rise = (s2_r & s3_r) & ~stable_r;

	// Sequencer states, one-hot
	localparam ST_IDLE  = 5'h01;
	localparam ST_PROG  = 5'h02;
	localparam ST_MEAS  = 5'h04;
	localparam ST_OVR   = 5'h08;
	localparam ST_ZERO  = 5'h10;

	reg  [4:0]               state_r;
	reg  [4:0]               state_nxt;
	reg  [15:0]              phase_cnt_r;   // Clocks spent in current phase
	wire                     phase_end;

	assign phase_end = (state_r == ST_MEAS) ? (phase_cnt_r == MEASURE_CYCLES - 16'h0001)
	                 : (phase_cnt_r == ZERO_CYCLES - 16'h0001);

	// Next state: launch walks progress, measure, override, zero in order
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: if (rise[0]) state_nxt = ST_PROG;        // R1
			ST_PROG: state_nxt = ST_MEAS;                     // R1
			ST_MEAS: if (phase_end) state_nxt = ST_OVR;       // R1
			ST_OVR:  state_nxt = ST_ZERO;                     // R1
			ST_ZERO: if (phase_end) state_nxt = ST_IDLE;      // R1
			default: state_nxt = ST_IDLE;
		endcase
	end

	// State register and phase timer
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_r     <= ST_IDLE;
			phase_cnt_r <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			if (state_nxt != state_r)
				phase_cnt_r <= 16'h0000;
			else
				phase_cnt_r <= phase_cnt_r + 16'h0001;
		end
	end

	// Decoded state flags and completion pulses
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			in_progress     <= 1'b0;
			measure_zero    <= 1'b0;
			override        <= 1'b0;
			comparator_out  <= 1'b0;
			conversion_done <= 1'b0;
			autozero_done   <= 1'b0;
		end else begin
			in_progress     <= (state_nxt != ST_IDLE);                  // R1
			measure_zero    <= (state_nxt == ST_MEAS);                  // R1
			override        <= (state_nxt == ST_OVR);                   // R1
			comparator_out  <= stable_r[1];                             // R2
			conversion_done <= (state_r == ST_MEAS) && phase_end;       // R4
			autozero_done   <= (state_r == ST_ZERO) && phase_end;       // R4
		end
	end

	// Ripple-free divider: stage k toggles when all lower stages are high.
	// A carry chain keeps every stage on the one clock; no stage output is
	// ever used as a clock, so all stages change on the same edge.
	wire [`DIV_STAGES:0]    div_carry;      // Toggle enable into each stage

	assign div_carry[0] = 1'b1;             // Stage zero toggles every clock

	genvar k;
	generate
		for (k = 0; k < `DIV_STAGES; k = k + 1) begin : g_div
			// Carry onward only while this stage and all below are high
			assign div_carry[k+1] = div_carry[k] & div_q[k];

			// One flip-flop per stage
			always @(posedge clk_sys or posedge sys_rst) begin
				if (sys_rst) begin
					div_q[k] <= 1'b0;                           // Square waves start low
				end else if (div_carry[k]) begin
					div_q[k] <= ~div_q[k];                      // R3
				end
			end
		end
	endgenerate

	// Reversible counter; clear has priority, counts only while measuring
	reg [`CNT_WIDTH-1:0] count_r;
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			count_r <= `COUNT_RESET;
		else if (stable_r[4])
			count_r <= `COUNT_RESET;                                 // R6
		else if (state_r == ST_MEAS) begin
			if (rise[2] && !rise[3])
				count_r <= count_r + 17'h00001;                      // R5
			else if (rise[3] && !rise[2])
				count_r <= count_r - 17'h00001;                      // R5
		end
	end

	// Readout: stop is end of measure; shift register drains MSB first
	reg  [`CNT_WIDTH-1:0] shift_r;
	reg  [4:0]            adv_left_r;      // Advance pulses still owed
	reg  [3:0]            adv_div_r;       // Spacing between advances
	wire                  stop_evt;
	wire                  adv_tick;

	assign stop_evt = (state_r == ST_MEAS) && phase_end;
	assign adv_tick = (adv_left_r != 5'h00) && (adv_div_r == `ADV_DIV - 4'h1);

	// Load on stop, then pace out seventeen advances
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			shift_r     <= `COUNT_RESET;
			adv_left_r  <= 5'h00;
			adv_div_r   <= 4'h0;
			advance     <= 1'b0;
			serial_data <= 1'b0;
			count_value <= `COUNT_RESET;
		end else begin
			advance <= adv_tick;
			if (stop_evt) begin
				shift_r     <= count_r;                              // R7
				count_value <= count_r;                              // R7
				serial_data <= count_r[`CNT_WIDTH-1];                // R9
				adv_left_r  <= `ADV_COUNT;                           // R8
				adv_div_r   <= 4'h0;
			end else begin
				// Pace the advances while any are still owed
				if (adv_left_r != 5'h00) begin
					adv_div_r <= (adv_div_r == `ADV_DIV - 4'h1) ? 4'h0 : adv_div_r + 4'h1;
					if (adv_tick)
						adv_left_r <= adv_left_r - 5'h01;            // R8
				end
				// Shift the cycle after each advance, so the current bit still
				// stands at the edge on which the processor takes it
				if (advance) begin
					shift_r     <= {shift_r[`CNT_WIDTH-2:0], 1'b0};  // R9
					serial_data <= shift_r[`CNT_WIDTH-2];            // R9
				end
			end
		end
	end

endmodule

// ### bench/cb_readout_assertions.sv
/* Timing checks on the readout block ports.
   Assumes one clock domain and an async high reset. */
`timescale 1ns/100ps
module cb_readout_assertions (
	input wire        clk_sys,
	input wire        sys_rst,
	input wire        count_dir,
	input wire        in_progress,
	input wire        measure_zero,
	input wire        override,
	input wire        comparator_out,
	input wire        conversion_done,
	input wire [11:0] div_q,
	input wire        advance,
	input wire [16:0] count_value
);
default clocking @(posedge clk_sys); endclocking
default disable iff (sys_rst);
// First edge after reset still sees reset values
chk_div_base: assert property (!$past(sys_rst) |-> $changed(div_q[0]))
	else $error("divider bit 0 not toggling");
chk_div_chain: assert property ($fell(div_q[0]) |-> $changed(div_q[1]))
	else $error("divider bit 1 not halving");
chk_comp_follow: assert property (count_dir [*6] |-> comparator_out)
	else $error("comparator not following direction");
chk_comp_low: assert property ((!count_dir) [*6] |-> !comparator_out)
	else $error("comparator not following low direction");
chk_div_count: assert property (!$past(sys_rst) |-> div_q == $past(div_q) + 12'h001)
	else $error("divider chain not halving");
chk_ovr_pulse: assert property ($rose(override) |=> !override)
	else $error("override longer than one cycle");
chk_launch_order: assert property ($rose(in_progress) |=> measure_zero)
	else $error("measure not after start");
chk_done_pulse: assert property (conversion_done |=> !conversion_done)
	else $error("done pulse too long");
chk_adv_space: assert property (advance |=> (!advance) [*3])
	else $error("advance pulses too close");
chk_load_hold: assert property (advance |-> $stable(count_value))
	else $error("count changed during readout");
cover property ($rose(in_progress));
cover property (advance);
cover property (conversion_done);
cover property ($rose(override));
endmodule
bind charge_balance_adc_count_readout cb_readout_assertions u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.count_dir(count_dir), .in_progress(in_progress), .measure_zero(measure_zero), .override(override),
	.comparator_out(comparator_out), .conversion_done(conversion_done), .div_q(div_q),
	.advance(advance), .count_value(count_value));

// ### bench/cb_result_reader.sv
/* Processor side: gathers the serial result.
   Assumes data is valid at each advance pulse. */
`timescale 1ns/100ps
module cb_result_reader (
	input wire        clk_sys,
	input wire        sys_rst,
	input wire        clr,
	input wire        advance,
	input wire        serial_data,
	output reg [16:0] word,
	output reg [4:0]  nb
);
// Shift in MSB first, count bits taken
always @(posedge clk_sys or posedge sys_rst) begin
	if (sys_rst) begin
		word <= 17'h00000;
		nb <= 5'h00;
	end else if (clr) begin
		word <= 17'h00000;
		nb <= 5'h00;
	end else if (advance) begin
		word <= {word[15:0], serial_data};
		nb <= nb + 5'h01;
	end
end
endmodule

// ### bench/charge_balance_adc_count_readout_tb.sv
/* Self-checking bench for the count readout.
   Assumes short measure and zero phases. */
`timescale 1ns/100ps
module charge_balance_adc_count_readout_tb;
reg         clk_sys = 0, sys_rst = 1, launch = 0, dir = 0, up = 0, dn = 0, clr = 0;
wire        inp, mz, ovr, cmp, cdone, azd, adv, sd;
wire [11:0] dq;
wire [16:0] cv, word;
wire [4:0]  nb;
integer     fails = 0, n_compared = 0, i, j, k;
reg  [31:0] s = 32'hB98B0420;
reg  [16:0] e;
reg         cd, az, ov;
always #10 clk_sys = ~clk_sys;
charge_balance_adc_count_readout #(.MEASURE_CYCLES(16'h0190), .ZERO_CYCLES(16'h0008)) i_dut (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .conversion_launch(launch), .count_dir(dir), .up_pulse(up),
	.down_pulse(dn), .counter_clear(clr), .in_progress(inp), .measure_zero(mz), .override(ovr),
	.comparator_out(cmp), .conversion_done(cdone), .autozero_done(azd), .div_q(dq), .advance(adv),
	.serial_data(sd), .count_value(cv));
cb_result_reader i_rd (.clk_sys(clk_sys), .sys_rst(sys_rst), .clr(clr), .advance(adv),
	.serial_data(sd), .word(word), .nb(nb));
function [31:0] nx(input [31:0] v);
	nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
task st(input integer n); begin repeat (n) @(posedge clk_sys); #1; end endtask
task chk(input [16:0] a, input [16:0] b); begin
	n_compared = n_compared + 1;
	if (a !== b) begin
		fails = fails + 1;
		$display("[FAIL] %0t got %h exp %h", $time, a, b);
	end
end endtask
task results; begin
	$display("compared %0d fails %0d", n_compared, fails);
	if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
	else $display("MISMATCHES SEEN");
	$finish;
end endtask
task to(input c); begin if (c !== 1'b1) begin fails = fails + 1; results; end end endtask
// One conversion: n random pulses, optional mid clear and refused launch
task conv(input [7:0] n, input mid); begin
	clr = 1; st(3); clr = 0; e = 0; cd = 0; az = 0; ov = 0;
	launch = 1; st(4); launch = 0;
	k = 0; while (!mz && k < 50) begin st(1); k = k + 1; end to(mz);
	chk(inp, 17'h1);
	for (i = 0; i < n; i = i + 1) begin
		s = nx(s); dir = s[2]; up = s[0]; dn = !s[0]; e = s[0] ? e + 1 : e - 1;
		st(3); up = 0; dn = 0; st(3);
	end
	chk(cmp, dir);
	if (mid) begin launch = 1; clr = 1; st(4); launch = 0; clr = 0; e = 0; end
	k = 0; while (nb < 17 && k < 900) begin st(1); cd = cd | cdone; az = az | azd; ov = ov | ovr; k = k + 1; end
	to(nb == 17); st(12);
	chk(nb, 17);
	chk(word, e);
	chk(cv, e);
	chk({cd, az}, 17'h3);
	chk(ov, 17'h1);
	$display("conversion of %0d pulses done", n);
end endtask
initial begin
	st(5); sys_rst = 0; st(5);
	conv(8'h00, 0); conv(8'h1E, 1); conv(8'h06, 0);
	for (j = 0; j < 6; j = j + 1) begin s = nx(s); conv({3'h0, s[4:0]} + 8'h01, 0); end
	results;
end
endmodule
